// ===== design/dcpm_cfg.svh
`ifndef DCPM_CFG_SVH
`define DCPM_CFG_SVH
// parameter ram placement
`define DCPM_PRAM_SYS_BASE 32'h01c04000
`define DCPM_PRAM_SEL 4'h4
`define DCPM_SET_STRIDE 32'h00000020
`define DCPM_NUM_SETS 128
`define DCPM_NUM_CH 64
`define DCPM_NUM_QDMA 8
`define DCPM_NULL_LINK 16'hffff
// word index within a set
`define DCPM_W_OPT 3'h0
`define DCPM_W_SRC 3'h1
`define DCPM_W_AB 3'h2
`define DCPM_W_DST 3'h3
`define DCPM_W_BIDX 3'h4
`define DCPM_W_LINK 3'h5
`define DCPM_W_CIDX 3'h6
`define DCPM_W_THIRD_DIM_COUNT 3'h7
// option word fields
`define DCPM_OPT_SYNC_AB 2
`define DCPM_OPT_MODE 11
`define DCPM_OPT_CODE_LSB 12
`define DCPM_OPT_FIN_IRQ 20
`define DCPM_OPT_INT_IRQ 21
`define DCPM_OPT_FIN_CHAIN 22
`define DCPM_OPT_INT_CHAIN 23
// control register offsets
`define DCPM_ESR_LO 16'h1000
`define DCPM_ESR_HI 16'h1004
`define DCPM_ER_LO 16'h1008
`define DCPM_ER_HI 16'h100c
`define DCPM_CER_LO 16'h1010
`define DCPM_CER_HI 16'h1014
`define DCPM_IPR_LO 16'h1018
`define DCPM_IPR_HI 16'h101c
`define DCPM_EMR_LO 16'h1020
`define DCPM_EMR_HI 16'h1024
`define DCPM_STAT 16'h1028
`define DCPM_QMAP_BASE 16'h1200
`define DCPM_QMAP_RST 10'h000
`endif

// ===== design/dcpm_pkg.sv
package dcpm_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EVAL,
    ST_SUBMIT,
    ST_LINK
  } dcpm_state_type;
  typedef logic [31:0] dcpm_word_type;
endpackage : dcpm_pkg

// ===== design/dcpm_top.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "dcpm_cfg.svh"
// Function
// - array-sync: second times third count requests; final when both counts are one
// - frame-sync: third-count requests of first times second bytes; final at third one
// - set completes after requested transfers submitted; null and dummy sets not counted
// - final request gives final codes and triggers link reload or null load
// - six-bit completion code picks bit of chained-event and irq-pending registers
// - final enables for last request, intermediate for others, never both together
// - transfer controller reports completions that enable chaining or irq; device accepts every report
// - link value ffff is the null link and ends the chain
// - event on a null set is flagged as error until software clears it
// - mode bit zero: completion comes from transfer controller report
// - mode bit one: completion code generated internally at submission
// - dummy or null sets submit nothing but still post requested codes
// - each of 64 channels has one fixed hardware event
// - channel stays usable by manual, chained trigger, reload or qdma use
// - channel n always uses parameter set n
// - sets are consecutive 32-byte blocks from the parameter ram base
// - sets 64 to 127 have no channel, only reload or qdma use
// - null-set service clears the pending event and sets the missed bit
// - after reset every qdma channel points at parameter set 0
module dcpm_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [63:0] i_sync_event,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_tr_valid,
  input wire logic i_tr_ready,
  output logic [6:0] o_tr_set,
  output logic [31:0] o_tr_src,
  output logic [31:0] o_tr_dst,
  output logic [15:0] o_tr_first_dim_byte_count,
  output logic [15:0] o_tr_second_dim_count,
  output logic [5:0] o_tr_code,
  output logic o_tr_final,
  output logic o_tr_chain_en,
  output logic o_tr_irq_en,
  input wire logic i_cmpl_valid,
  input wire logic [5:0] i_cmpl_code,
  input wire logic i_cmpl_final,
  input wire logic i_cmpl_chain,
  input wire logic i_cmpl_irq
);

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  dcpm_pkg::dcpm_word_type pram [0:`DCPM_NUM_SETS*8-1];
  dcpm_pkg::dcpm_state_type state_q;
  logic [63:0] s1_q, s2_q, s3_q;
  logic [63:0] er_q, cer_q, ipr_q, emr_q;
  logic [5:0] ch_q;
  logic tr_early_q;
  logic last_final_q;
  logic [9:0] qmap_q [0:`DCPM_NUM_QDMA-1];

  function automatic logic [5:0] dcpm_pick(input logic [63:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction : dcpm_pick

  // ----------------------------------------
  // current set fields
  // ----------------------------------------
  logic [6:0] set_idx;
  dcpm_pkg::dcpm_word_type w_opt, w_src, w_ab, w_dst, w_bidx, w_link, w_cidx, w_third_dim_count;
  assign set_idx = {1'b0, ch_q};
  assign w_opt = pram[{set_idx, `DCPM_W_OPT}];
  assign w_src = pram[{set_idx, `DCPM_W_SRC}];
  assign w_ab = pram[{set_idx, `DCPM_W_AB}];
  assign w_dst = pram[{set_idx, `DCPM_W_DST}];
  assign w_bidx = pram[{set_idx, `DCPM_W_BIDX}];
  assign w_link = pram[{set_idx, `DCPM_W_LINK}];
  assign w_cidx = pram[{set_idx, `DCPM_W_CIDX}];
  assign w_third_dim_count = pram[{set_idx, `DCPM_W_THIRD_DIM_COUNT}];

  logic sync_ab, zero_cnt, null_link, is_final;
  logic [5:0] opt_code;
  assign sync_ab = w_opt[`DCPM_OPT_SYNC_AB];
  assign opt_code = w_opt[`DCPM_OPT_CODE_LSB +: 6];
  assign zero_cnt = (w_ab == 32'h00000000) && (w_third_dim_count[15:0] == 16'h0000);
  assign null_link = (w_link[15:0] == `DCPM_NULL_LINK);
  assign is_final = sync_ab ? (w_third_dim_count[15:0] == 16'h0001) :
                    ((w_ab[31:16] == 16'h0001) && (w_third_dim_count[15:0] == 16'h0001));

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic apb_wr, apb_rd, is_pram, is_qmap;
  logic [2:0] qidx;
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  assign apb_rd = i_psel && i_penable && !o_pready;
  // 32-byte sets at parameter ram base
  assign is_pram = (i_paddr[15:12] == `DCPM_PRAM_SEL);
  assign is_qmap = (i_paddr[15:5] == 11'(`DCPM_QMAP_BASE >> 5));
  assign qidx = i_paddr[4:2];

  function automatic logic [63:0] dcpm_w1(input logic [15:0] lo, input logic [15:0] hi,
                                          input logic [15:0] a, input logic [31:0] d);
    logic [63:0] m;
    m = 64'h0;
    if (a == lo) begin
      m[31:0] = d;
    end
    if (a == hi) begin
      m[63:32] = d;
    end
    return m;
  endfunction : dcpm_w1

  logic [63:0] esr_set, cer_clr, ipr_clr, emr_clr;
  assign esr_set = apb_wr ? dcpm_w1(`DCPM_ESR_LO, `DCPM_ESR_HI, i_paddr, i_pwdata) : 64'h0;
  assign cer_clr = apb_wr ? dcpm_w1(`DCPM_CER_LO, `DCPM_CER_HI, i_paddr, i_pwdata) : 64'h0;
  assign ipr_clr = apb_wr ? dcpm_w1(`DCPM_IPR_LO, `DCPM_IPR_HI, i_paddr, i_pwdata) : 64'h0;
  assign emr_clr = apb_wr ? dcpm_w1(`DCPM_EMR_LO, `DCPM_EMR_HI, i_paddr, i_pwdata) : 64'h0;

  // ----------------------------------------
  // completion sources
  // ----------------------------------------
  logic [63:0] svc_clr, cer_set, ipr_set, emr_set;
  logic zc_eval;
  assign zc_eval = (state_q == dcpm_pkg::ST_EVAL) && zero_cnt;
  always_comb begin
    svc_clr = 64'h0;
    cer_set = 64'h0;
    ipr_set = 64'h0;
    emr_set = 64'h0;
    if ((state_q == dcpm_pkg::ST_IDLE) && ((er_q | cer_q) != 64'h0)) begin
      svc_clr[dcpm_pick(er_q | cer_q)] = 1'b1;
    end
    // dummy or null posts codes internally
    if (zc_eval) begin
      cer_set[opt_code] = w_opt[`DCPM_OPT_FIN_CHAIN];
      ipr_set[opt_code] = w_opt[`DCPM_OPT_FIN_IRQ];
    end
    if (zc_eval && null_link) begin
      emr_set[ch_q] = 1'b1;
    end
    if ((state_q == dcpm_pkg::ST_SUBMIT) && i_tr_ready && tr_early_q) begin
      cer_set[o_tr_code] = cer_set[o_tr_code] | o_tr_chain_en;
      ipr_set[o_tr_code] = ipr_set[o_tr_code] | o_tr_irq_en;
    end
    if (i_cmpl_valid) begin
      cer_set[i_cmpl_code] = cer_set[i_cmpl_code] | i_cmpl_chain;
      ipr_set[i_cmpl_code] = ipr_set[i_cmpl_code] | i_cmpl_irq;
    end
  end

  // ----------------------------------------
  // event capture
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      s1_q <= 64'h0;
      s2_q <= 64'h0;
      s3_q <= 64'h0;
    end else begin
      s1_q <= i_sync_event;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // set wins over clear on every flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      er_q <= 64'h0;
      cer_q <= 64'h0;
      ipr_q <= 64'h0;
      emr_q <= 64'h0;
      last_final_q <= 1'b0;
    end else begin
      // event n sets channel n only
      er_q <= (er_q & ~svc_clr) | (s2_q & ~s3_q) | esr_set;
      cer_q <= (cer_q & ~svc_clr & ~cer_clr) | cer_set;
      ipr_q <= (ipr_q & ~ipr_clr) | ipr_set;
      emr_q <= (emr_q & ~emr_clr) | emr_set;
      if (i_cmpl_valid) begin
        last_final_q <= i_cmpl_final;
      end
    end
  end

  // ----------------------------------------
  // channel engine
  // ----------------------------------------
  logic [31:0] sb, db, sc, dc;
  assign sb = {{16{w_bidx[15]}}, w_bidx[15:0]};
  assign db = {{16{w_bidx[31]}}, w_bidx[31:16]};
  assign sc = {{16{w_cidx[15]}}, w_cidx[15:0]};
  assign dc = {{16{w_cidx[31]}}, w_cidx[31:16]};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_q <= dcpm_pkg::ST_IDLE;
      ch_q <= 6'h00;
      tr_early_q <= 1'b0;
      o_tr_valid <= 1'b0;
      o_tr_set <= 7'h00;
      o_tr_src <= 32'h0;
      o_tr_dst <= 32'h0;
      o_tr_first_dim_byte_count <= 16'h0;
      o_tr_second_dim_count <= 16'h0;
      o_tr_code <= 6'h00;
      o_tr_final <= 1'b0;
      o_tr_chain_en <= 1'b0;
      o_tr_irq_en <= 1'b0;
    end else begin
      case (state_q)
        dcpm_pkg::ST_IDLE: begin
          if ((er_q | cer_q) != 64'h0) begin
            ch_q <= dcpm_pick(er_q | cer_q);
            state_q <= dcpm_pkg::ST_EVAL;
          end
        end
        dcpm_pkg::ST_EVAL: begin
          if (zero_cnt) begin
            state_q <= null_link ? dcpm_pkg::ST_IDLE : dcpm_pkg::ST_LINK;
          end else begin
            o_tr_valid <= 1'b1;
            o_tr_set <= set_idx;
            o_tr_src <= w_src;
            o_tr_dst <= w_dst;
            o_tr_first_dim_byte_count <= w_ab[15:0];
            o_tr_second_dim_count <= sync_ab ? w_ab[31:16] : 16'h0001;
            o_tr_code <= opt_code;
            o_tr_final <= is_final;
            o_tr_chain_en <= is_final ? w_opt[`DCPM_OPT_FIN_CHAIN] : w_opt[`DCPM_OPT_INT_CHAIN];
            o_tr_irq_en <= is_final ? w_opt[`DCPM_OPT_FIN_IRQ] : w_opt[`DCPM_OPT_INT_IRQ];
            tr_early_q <= w_opt[`DCPM_OPT_MODE];
            state_q <= dcpm_pkg::ST_SUBMIT;
          end
        end
        dcpm_pkg::ST_SUBMIT: begin
          if (i_tr_ready) begin
            o_tr_valid <= 1'b0;
            state_q <= o_tr_final ? dcpm_pkg::ST_LINK : dcpm_pkg::ST_IDLE;
          end
        end
        dcpm_pkg::ST_LINK: begin
          state_q <= dcpm_pkg::ST_IDLE;
        end
        default: begin
          state_q <= dcpm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // parameter ram writes
  // ----------------------------------------
  logic [6:0] link_set;
  assign link_set = w_link[11:5];
  always_ff @(posedge i_clk_sys) begin
    if ((state_q == dcpm_pkg::ST_SUBMIT) && i_tr_ready && !o_tr_final) begin
      if (sync_ab) begin
        pram[{set_idx, `DCPM_W_THIRD_DIM_COUNT}] <= {w_third_dim_count[31:16], w_third_dim_count[15:0] - 16'h0001};
        pram[{set_idx, `DCPM_W_SRC}] <= w_src + sc;
        pram[{set_idx, `DCPM_W_DST}] <= w_dst + dc;
      end else if (w_ab[31:16] == 16'h0001) begin
        pram[{set_idx, `DCPM_W_AB}] <= {w_link[31:16], w_ab[15:0]};
        pram[{set_idx, `DCPM_W_THIRD_DIM_COUNT}] <= {w_third_dim_count[31:16], w_third_dim_count[15:0] - 16'h0001};
        pram[{set_idx, `DCPM_W_SRC}] <= w_src + sc;
        pram[{set_idx, `DCPM_W_DST}] <= w_dst + dc;
      end else begin
        pram[{set_idx, `DCPM_W_AB}] <= {w_ab[31:16] - 16'h0001, w_ab[15:0]};
        pram[{set_idx, `DCPM_W_SRC}] <= w_src + sb;
        pram[{set_idx, `DCPM_W_DST}] <= w_dst + db;
      end
    end
    // null link loads the null set
    if (state_q == dcpm_pkg::ST_LINK) begin
      for (int w = 0; w < 8; w++) begin
        if (null_link) begin
          pram[{set_idx, 3'(w)}] <= (3'(w) == `DCPM_W_LINK) ? {16'h0, `DCPM_NULL_LINK} : 32'h0;
        end else begin
          pram[{set_idx, 3'(w)}] <= pram[{link_set, 3'(w)}];
        end
      end
    end
    // sets 64 to 127 reachable only by software and links
    if (apb_wr && is_pram) begin
      pram[i_paddr[11:2]] <= i_pwdata;
    end
  end

  // ----------------------------------------
  // qdma map registers
  // ----------------------------------------
  genvar q;
  generate
    for (q = 0; q < `DCPM_NUM_QDMA; q++) begin : g_qmap
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
          // qdma maps point at set 0
          qmap_q[q] <= `DCPM_QMAP_RST;
        end else if (apb_wr && is_qmap && (qidx == 3'(q))) begin
          qmap_q[q] <= {i_pwdata[11:5], i_pwdata[4:2]};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // apb read and ready
  // ----------------------------------------
  logic [31:0] rd_d;
  logic err_d;
  always_comb begin
    rd_d = 32'h0;
    err_d = 1'b0;
    if (is_pram) begin
      rd_d = pram[i_paddr[11:2]];
    end else if (is_qmap) begin
      rd_d = {20'h0, qmap_q[qidx][9:3], qmap_q[qidx][2:0], 2'b00};
    end else begin
      case (i_paddr)
        `DCPM_ESR_LO, `DCPM_ESR_HI: rd_d = 32'h0;
        `DCPM_ER_LO: rd_d = er_q[31:0];
        `DCPM_ER_HI: rd_d = er_q[63:32];
        `DCPM_CER_LO: rd_d = cer_q[31:0];
        `DCPM_CER_HI: rd_d = cer_q[63:32];
        `DCPM_IPR_LO: rd_d = ipr_q[31:0];
        `DCPM_IPR_HI: rd_d = ipr_q[63:32];
        `DCPM_EMR_LO: rd_d = emr_q[31:0];
        `DCPM_EMR_HI: rd_d = emr_q[63:32];
        `DCPM_STAT: rd_d = {22'h0, last_final_q, (state_q != dcpm_pkg::ST_IDLE), 2'b00, ch_q};
        default: err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_rd;
      o_pslverr <= apb_rd && err_d;
      if (apb_rd) begin
        o_prdata <= i_pwrite ? 32'h0 : rd_d;
      end
    end
  end

endmodule : dcpm_top

// ===== verif/dcpm_sva.sv
`timescale 1ns/100ps
module dcpm_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_tr_valid,
  input wire logic i_tr_ready,
  input wire logic [6:0] o_tr_set,
  input wire logic [5:0] o_tr_code,
  input wire logic o_tr_final,
  input wire logic [15:0] o_tr_second_dim_count
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  property p_resp; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_resp: assert property (p_resp) else $error("no ready after access");
  property p_cause; o_pready |-> $past(i_psel) && $past(i_penable); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hold;
    o_tr_valid && !i_tr_ready |=> o_tr_valid && $stable({o_tr_set, o_tr_code, o_tr_final, o_tr_second_dim_count});
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before accept");
  property p_gap; o_tr_valid && i_tr_ready |=> !o_tr_valid [*2]; endproperty
  a_gap: assert property (p_gap) else $error("request too soon after accept");
  property p_set; o_tr_valid |-> o_tr_set < 7'h40; endproperty
  a_set: assert property (p_set) else $error("request from a set without channel");
  property p_rst; $rose(i_rst_b) |-> !o_tr_valid && !o_pready && !o_pslverr; endproperty
  a_rst: assert property (p_rst) else $error("outputs active out of reset");
  c_final: cover property (o_tr_valid && i_tr_ready && o_tr_final);
  c_mid: cover property (o_tr_valid && i_tr_ready && !o_tr_final);
  c_slverr: cover property (o_pslverr);
endmodule : dcpm_chk
bind dcpm_top dcpm_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_tr_valid(o_tr_valid),
  .i_tr_ready(i_tr_ready), .o_tr_set(o_tr_set), .o_tr_code(o_tr_code),
  .o_tr_final(o_tr_final), .o_tr_second_dim_count(o_tr_second_dim_count));

// ===== verif/dcpm_tc_model.sv
`timescale 1ns/100ps
module dcpm_tc_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_tr_valid,
  input wire logic [5:0] i_tr_code,
  input wire logic i_tr_final,
  input wire logic i_tr_chain_en,
  input wire logic i_tr_irq_en,
  input wire logic i_slow,
  input wire logic i_mute,
  output logic o_tr_ready,
  output logic o_cmpl_valid,
  output logic [5:0] o_cmpl_code,
  output logic o_cmpl_final,
  output logic o_cmpl_chain,
  output logic o_cmpl_irq
);
  logic [1:0] wait_q;
  logic [8:0] rep_q;
  assign {o_cmpl_code, o_cmpl_final, o_cmpl_chain, o_cmpl_irq} = rep_q;
  always_ff @(posedge i_clk_sys) begin
    o_cmpl_valid <= 1'b0;
    rep_q <= ~rep_q;
    if (!i_rst_b) begin
      o_tr_ready <= 1'b0;
      wait_q <= 2'h0;
      rep_q <= 9'h0;
    end else if (o_tr_ready && i_tr_valid) begin
      o_tr_ready <= 1'b0;
      wait_q <= 2'h0;
      o_cmpl_valid <= (i_tr_chain_en || i_tr_irq_en) && !i_mute;
      rep_q <= {i_tr_code, i_tr_final, i_tr_chain_en, i_tr_irq_en};
    end else if (i_tr_valid) begin
      wait_q <= wait_q + 2'h1;
      o_tr_ready <= !i_slow || (wait_q == 2'h3);
    end
  end
endmodule : dcpm_tc_model

// ===== verif/test_dcpm_top.sv
`timescale 1ns/100ps
`include "dcpm_cfg.svh"
module test_dcpm_top;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr, trv, trr, tfin, tch, tirq;
  logic cv, cf, cch, cirq, slow, mute, fin_q, err_q;
  logic [63:0] sev;
  logic [15:0] paddr, tacnt, tbcnt, bc_q, ac_q;
  logic [31:0] pwdata, prdata, tsrc, tdst, rd_q, src_q, dst_q;
  logic [6:0] tset, set_q;
  logic [5:0] tcode, cc;
  int bad_count = 0;
  int comparisons = 0;
  int n_tr = 0;
  always #20 clk = ~clk;
  dcpm_top i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_sync_event(sev), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_tr_valid(trv),
    .i_tr_ready(trr), .o_tr_set(tset), .o_tr_src(tsrc), .o_tr_dst(tdst), .o_tr_first_dim_byte_count(tacnt),
    .o_tr_second_dim_count(tbcnt), .o_tr_code(tcode), .o_tr_final(tfin), .o_tr_chain_en(tch),
    .o_tr_irq_en(tirq), .i_cmpl_valid(cv), .i_cmpl_code(cc), .i_cmpl_final(cf),
    .i_cmpl_chain(cch), .i_cmpl_irq(cirq));
  dcpm_tc_model i_tc (.i_clk_sys(clk), .i_rst_b(rst_b), .i_tr_valid(trv), .i_tr_code(tcode),
    .i_tr_final(tfin), .i_tr_chain_en(tch), .i_tr_irq_en(tirq), .i_slow(slow),
    .i_mute(mute), .o_tr_ready(trr), .o_cmpl_valid(cv), .o_cmpl_code(cc),
    .o_cmpl_final(cf), .o_cmpl_chain(cch), .o_cmpl_irq(cirq));
  always @(posedge clk) if (trv === 1'b1 && trr === 1'b1) begin
    n_tr <= n_tr + 1;
    fin_q <= tfin;
    set_q <= tset;
    bc_q <= tbcnt;
    ac_q <= tacnt;
    src_q <= tsrc;
    dst_q <= tdst;
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_cnt(input int want);
    int n = 0;
    while (n_tr != want && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (n_tr != want) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_cnt
  task automatic poll(input logic [15:0] a, input logic [31:0] m);
    int n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd_q & m) !== m && n < 20);
    check(rd_q & m, m);
  endtask : poll
  task automatic prog(input int s, input logic [31:0] o, ab, lk, cnt);
    logic [31:0] w[8];
    w = '{o, 32'h8000_0000, ab, 32'h8000_1000, 32'h0, lk, 32'h0, cnt};
    for (int i = 0; i < 8; i++) apb(1'b1, 16'(32'h4000 + s * 32 + i * 4), w[i]);
  endtask : prog
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_array();
    prog(2, 32'h0010_5000, 32'h0002_0010, 32'h0002_ffff, 32'h2);
    for (int k = 1; k < 6; k++) begin
      sev[2] <= 1'b1;
      repeat (3) @(posedge clk);
      sev[2] <= 1'b0;
      if (k == 5) break;
      wait_cnt(k);
      check(32'(fin_q), 32'(k == 4));
      check(32'(set_q), 32'h2);
      check(32'(ac_q), 32'h10);
      apb(1'b0, `DCPM_IPR_LO, 32'h0);
      check(rd_q, (k == 4) ? 32'h20 : 32'h0);
    end
    poll(`DCPM_EMR_LO, 32'h4);
    check(32'(n_tr), 32'h4);
    apb(1'b0, `DCPM_ER_LO, 32'h0);
    check(rd_q, 32'h0);
    apb(1'b1, `DCPM_EMR_LO, 32'h4);
    apb(1'b1, `DCPM_IPR_LO, 32'h20);
  endtask : t_array
  task automatic t_frame();
    slow <= 1'b1;
    prog(3, 32'h0020_7004, 32'h0003_0008, 32'h0000_ffff, 32'h2);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `DCPM_ESR_LO, 32'h8);
      wait_cnt(5 + k);
      check(32'(bc_q), 32'h3);
      check(32'(ac_q), 32'h8);
      check(32'(fin_q), 32'(k));
      apb(1'b0, `DCPM_IPR_LO, 32'h0);
      check(rd_q, (k == 1) ? 32'h0 : 32'h80);
      apb(1'b1, `DCPM_IPR_LO, 32'h80);
    end
    slow <= 1'b0;
  endtask : t_frame
  task automatic t_early();
    mute <= 1'b1;
    prog(9, 32'h0, 32'h0, 32'h0000_ffff, 32'h0);
    prog(4, 32'h0050_9800, 32'h0001_0004, 32'h0000_ffff, 32'h1);
    apb(1'b1, `DCPM_ESR_LO, 32'h10);
    wait_cnt(7);
    check(src_q, 32'h8000_0000);
    check(dst_q, 32'h8000_1000);
    apb(1'b0, `DCPM_IPR_LO, 32'h0);
    check(rd_q, 32'h200);
    poll(`DCPM_EMR_LO, 32'h200);
    apb(1'b0, `DCPM_CER_LO, 32'h0);
    check(rd_q, 32'h0);
    apb(1'b1, `DCPM_EMR_LO, 32'h200);
    apb(1'b1, `DCPM_IPR_LO, 32'h200);
    mute <= 1'b0;
  endtask : t_early
  task automatic t_dummy();
    prog(64, 32'h0010_c000, 32'h0001_0004, 32'h0000_ffff, 32'h1);
    prog(5, 32'h0010_b000, 32'h0, 32'h0000_4800, 32'h0);
    apb(1'b1, `DCPM_ESR_LO, 32'h20);
    poll(`DCPM_IPR_LO, 32'h800);
    check(32'(n_tr), 32'h7);
    apb(1'b1, `DCPM_ESR_LO, 32'h20);
    wait_cnt(8);
    check(32'(set_q), 32'h5);
    poll(`DCPM_IPR_LO, 32'h1000);
    apb(1'b0, `DCPM_STAT, 32'h0);
    check(rd_q, 32'h0000_0205);
  endtask : t_dummy
  initial begin
    rst_b <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 16'h0;
    pwdata <= 32'h0;
    sev <= 64'h0;
    slow <= 1'b0;
    mute <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, `DCPM_QMAP_BASE, 32'h0);
    check(rd_q, 32'h0);
    apb(1'b1, `DCPM_QMAP_BASE + 16'h0004, 32'h0000_0fe4);
    apb(1'b0, `DCPM_QMAP_BASE + 16'h0004, 32'h0);
    check(rd_q, 32'h0000_0fe4);
    apb(1'b0, 16'h0ffc, 32'h0);
    check(32'(err_q), 32'h1);
    t_array();
    t_frame();
    t_early();
    t_dummy();
    report_and_stop();
  end
endmodule : test_dcpm_top
